// ### rtl/exc_pkg.sv
/*
 * Constants and types for the exception entry unit: vectors, mode codes,
 * status bit positions, link offsets and latency counts.
 * Assumes one 40 MHz core clock and a synchronous active-high reset.
 */
package exc_pkg;
    localparam int          ADDR_W        = 32;
    localparam int          PSR_W         = 32;
    localparam logic [4:0]  MODE_USR      = 5'h10;
    localparam logic [4:0]  MODE_FIQ      = 5'h11;
    localparam logic [4:0]  MODE_IRQ      = 5'h12;
    localparam logic [4:0]  MODE_SVC      = 5'h13;
    localparam logic [4:0]  MODE_ABT      = 5'h17;
    localparam logic [4:0]  MODE_UND      = 5'h1b;
    localparam logic [4:0]  MODE_SYS      = 5'h1f;
    localparam int          BIT_IMASK     = 7;
    localparam int          BIT_FMASK     = 6;
    localparam int          BIT_COMPACT   = 5;
    localparam logic [31:0] VEC_RESET     = 32'h0000_0000;
    localparam logic [31:0] VEC_UND       = 32'h0000_0004;
    localparam logic [31:0] VEC_SVC       = 32'h0000_0008;
    localparam logic [31:0] VEC_PREFETCH_FAULT      = 32'h0000_000c;
    localparam logic [31:0] VEC_DATA_FAULT      = 32'h0000_0010;
    localparam logic [31:0] VEC_IRQ       = 32'h0000_0018;
    localparam logic [31:0] VEC_FIQ       = 32'h0000_001c;
    localparam logic [31:0] OFS_2         = 32'h0000_0002;
    localparam logic [31:0] OFS_4         = 32'h0000_0004;
    localparam logic [31:0] OFS_8         = 32'h0000_0008;
    localparam logic [31:0] PSR_RESET     = 32'h0000_00d3;
    localparam int          T_SYNC_MAX    = 3;
    localparam int          T_LDM         = 20;
    localparam int          T_EXC         = 3;
    localparam int          T_FIQ         = 2;
    localparam int          T_MIN_LAT     = 4;

    typedef enum logic [2:0] {
        EXC_NONE  = 3'h0,
        EXC_RESET = 3'h1,
        EXC_DATA_FAULT  = 3'h2,
        EXC_FIQ   = 3'h3,
        EXC_IRQ   = 3'h4,
        EXC_PREFETCH_FAULT  = 3'h5,
        EXC_UND   = 3'h6,
        EXC_SVC   = 3'h7
    } exc_kind_t;

    // entry sequencer: gray along idle -> entry -> fetch
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_ENTER = 2'b01,
        ST_FETCH = 2'b11
    } ent_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic        is_bl;
        logic        is_svc;
        logic        is_undef;
        logic        prefetch_fault_mark;
        logic        is_return;
        logic        ret_data_fault;
    } instr_end_t;

    typedef struct packed {
        logic        valid;
        logic        is_fetch;
        logic        is_swap;
        logic        is_block;
        logic        is_word;
    } mem_cycle_t;
endpackage : exc_pkg

// ### rtl/exc_entry.sv
/*
 * Exception entry and priority unit of the core: samples interrupt and fault
 * inputs, ranks pending exceptions at instruction end, computes link value,
 * vector, mode and mask updates, and gates register writes after block transfer faults.
 * Assumes the decoder reports instruction ends and memory cycles on CLK_I.
 */
`timescale 1ns/1ps
module exc_entry
    import exc_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        FAST_IRQ_N_I,
    input  wire logic        IRQ_REQ_N_I,
    input  wire logic        IRQ_SYNC_SELECT_I,
    input  wire logic        MEM_FAULT_I,
    input  wire mem_cycle_t  MEM_CYC_I,
    input  wire instr_end_t  INSTR_END_I,
    input  wire logic        FLUSH_I,
    input  wire logic        PSR_WR_I,
    input  wire logic [31:0] PSR_WDATA_I,
    input  wire logic [31:0] SAVED_PSR_I,
    input  wire logic        BLOCK_DONE_I,
    output logic             ENTRY_O,
    output logic [31:0]      VECTOR_O,
    output logic [31:0]      LINK_O,
    output logic             LINK_WE_O,
    output logic [31:0]      STATUS_O,
    output logic [31:0]      SAVED_STATUS_O,
    output logic             REG_WR_BLOCK_O,
    output logic             BASE_WB_OK_O,
    output logic             STATE_UNDO_O
);
    logic [1:0]  fsync_r, irq_sync_select_r;
    logic        fiq_lvl, irq_lvl;
    logic [31:0] psr_r, psr_nxt, saved_status_reg_r, saved_status_reg_nxt;
    logic [31:0] link_r, link_nxt, vec_r, vec_nxt;
    logic        entry_r, entry_nxt, lwe_r, lwe_nxt;
    logic        data_fault_r, data_fault_nxt, blk_r, blk_nxt;
    logic        undo_r, undo_nxt, bwb_r, bwb_nxt;
    logic        chain_r, chain_nxt;
    logic [31:0] chain_pc_r, chain_pc_nxt;
    ent_state_t  st_r, st_nxt;
    exc_kind_t   kind;
    logic        priv;
    localparam int FIQ_ENTRY_MAX = T_FIQ;

    // first stage is read only by the second
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            fsync_r <= 2'b11;
            irq_sync_select_r <= 2'b11;
        end else begin
            fsync_r <= {fsync_r[0], FAST_IRQ_N_I};
            irq_sync_select_r <= {irq_sync_select_r[0], IRQ_REQ_N_I};
        end
    end

    // synchronous mode skips the synchroniser; async costs the extra cycles
    always_comb begin
        fiq_lvl = IRQ_SYNC_SELECT_I ? ~FAST_IRQ_N_I : ~fsync_r[1];
        irq_lvl = IRQ_SYNC_SELECT_I ? ~IRQ_REQ_N_I  : ~irq_sync_select_r[1];
        priv    = psr_r[4:0] != MODE_USR;
    end

    // fixed ranking at the end of an instruction
    always_comb begin
        kind = EXC_NONE;
        if (INSTR_END_I.valid) begin
            if (data_fault_r)                                    kind = EXC_DATA_FAULT;
            else if (fiq_lvl && !psr_r[BIT_FMASK])         kind = EXC_FIQ;
            else if (irq_lvl && !psr_r[BIT_IMASK])         kind = EXC_IRQ;
            else if (INSTR_END_I.prefetch_fault_mark && !FLUSH_I)    kind = EXC_PREFETCH_FAULT;
            else if (INSTR_END_I.is_undef)                 kind = EXC_UND;
            else if (INSTR_END_I.is_svc)                   kind = EXC_SVC;
        end
    end

    always_comb begin
        psr_nxt      = psr_r;
        saved_status_reg_nxt     = saved_status_reg_r;
        link_nxt     = link_r;
        vec_nxt      = vec_r;
        entry_nxt    = 1'b0;
        lwe_nxt      = 1'b0;
        data_fault_nxt     = data_fault_r;
        blk_nxt      = blk_r;
        undo_nxt     = 1'b0;
        bwb_nxt      = 1'b0;
        chain_nxt    = chain_r;
        chain_pc_nxt = chain_pc_r;
        st_nxt       = st_r;
        // privileged writes only; user writes leave the masks alone
        if (PSR_WR_I && priv) begin
            psr_nxt = {psr_r[31:8], PSR_WDATA_I[7:6], psr_r[5], PSR_WDATA_I[4:0]};
        end
        if (INSTR_END_I.valid && INSTR_END_I.is_return) begin
            psr_nxt = SAVED_PSR_I;
        end
        if (INSTR_END_I.valid && INSTR_END_I.is_bl) begin
            link_nxt = INSTR_END_I.pc + (psr_r[BIT_COMPACT] ? OFS_2 : OFS_4);
            lwe_nxt  = 1'b1;
        end
        unique case (st_r)
            ST_RUN: begin
                if (kind != EXC_NONE) begin
                    entry_nxt = 1'b1;
                    lwe_nxt   = 1'b1;
                    saved_status_reg_nxt  = psr_r;
                    psr_nxt[BIT_COMPACT] = 1'b0;
                    st_nxt    = ST_ENTER;
                    unique case (kind)
                        EXC_DATA_FAULT: begin
                            data_fault_nxt = 1'b0;
                            link_nxt = INSTR_END_I.pc + OFS_8;
                            vec_nxt  = VEC_DATA_FAULT;
                            psr_nxt[4:0] = MODE_ABT;
                            psr_nxt[BIT_IMASK] = 1'b1;
                            // chained fast entry resumes the abort handler
                            chain_nxt    = fiq_lvl && !psr_r[BIT_FMASK];
                            chain_pc_nxt = VEC_DATA_FAULT;
                        end
                        EXC_FIQ: begin
                            link_nxt = INSTR_END_I.pc + OFS_4;
                            vec_nxt  = VEC_FIQ;
                            psr_nxt[4:0] = MODE_FIQ;
                            psr_nxt[BIT_IMASK] = 1'b1;
                            psr_nxt[BIT_FMASK] = 1'b1;
                        end
                        EXC_IRQ: begin
                            link_nxt = INSTR_END_I.pc + OFS_4;
                            vec_nxt  = VEC_IRQ;
                            psr_nxt[4:0] = MODE_IRQ;
                            psr_nxt[BIT_IMASK] = 1'b1;
                        end
                        EXC_PREFETCH_FAULT: begin
                            link_nxt = INSTR_END_I.pc + OFS_4;
                            vec_nxt  = VEC_PREFETCH_FAULT;
                            psr_nxt[4:0] = MODE_ABT;
                            psr_nxt[BIT_IMASK] = 1'b1;
                        end
                        EXC_UND: begin
                            link_nxt = INSTR_END_I.pc + (psr_r[BIT_COMPACT] ? OFS_2 : OFS_4);
                            vec_nxt  = VEC_UND;
                            psr_nxt[4:0] = MODE_UND;
                            psr_nxt[BIT_IMASK] = 1'b1;
                        end
                        default: begin
                            link_nxt = INSTR_END_I.pc + (psr_r[BIT_COMPACT] ? OFS_2 : OFS_4);
                            vec_nxt  = VEC_SVC;
                            psr_nxt[4:0] = MODE_SVC;
                            psr_nxt[BIT_IMASK] = 1'b1;
                        end
                    endcase
                end
            end
            ST_ENTER: begin
                st_nxt = ST_FETCH;
                if (chain_r) begin
                    entry_nxt = 1'b1;
                    lwe_nxt   = 1'b1;
                    link_nxt  = chain_pc_r + OFS_4;
                    vec_nxt   = VEC_FIQ;
                    saved_status_reg_nxt  = psr_r;
                    psr_nxt[4:0] = MODE_FIQ;
                    psr_nxt[BIT_IMASK] = 1'b1;
                    psr_nxt[BIT_FMASK] = 1'b1;
                    chain_nxt = 1'b0;
                end
            end
            ST_FETCH: st_nxt = ST_RUN;
        endcase
        // classified last so a new fault beats a clear in the same cycle
        if (BLOCK_DONE_I) blk_nxt = 1'b0;
        if (MEM_CYC_I.valid && MEM_FAULT_I && !MEM_CYC_I.is_fetch) begin
            data_fault_nxt = 1'b1;
            if (MEM_CYC_I.is_swap)  undo_nxt = 1'b1;
            if (MEM_CYC_I.is_word)  bwb_nxt  = 1'b1;
            if (MEM_CYC_I.is_block) begin
                blk_nxt = 1'b1;
                bwb_nxt = 1'b1;
            end
        end
    end

    // link and saved status carry no reset; their contents are undefined
    always_ff @(posedge CLK_I) begin
        link_r     <= link_nxt;
        saved_status_reg_r     <= saved_status_reg_nxt;
        chain_pc_r <= chain_pc_nxt;
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            psr_r   <= PSR_RESET;
            vec_r   <= VEC_RESET;
            entry_r <= 1'b1;
            lwe_r   <= 1'b0;
            data_fault_r  <= 1'b0;
            blk_r   <= 1'b0;
            undo_r  <= 1'b0;
            bwb_r   <= 1'b0;
            chain_r <= 1'b0;
            st_r    <= ST_RUN;
        end else begin
            psr_r   <= psr_nxt;
            vec_r   <= vec_nxt;
            entry_r <= entry_nxt;
            lwe_r   <= lwe_nxt;
            data_fault_r  <= data_fault_nxt;
            blk_r   <= blk_nxt;
            undo_r  <= undo_nxt;
            bwb_r   <= bwb_nxt;
            chain_r <= chain_nxt;
            st_r    <= st_nxt;
        end
    end

    always_comb begin
        ENTRY_O        = entry_r;
        VECTOR_O       = vec_r;
        LINK_O         = link_r;
        LINK_WE_O      = lwe_r;
        STATUS_O       = psr_r;
        SAVED_STATUS_O = saved_status_reg_r;
        REG_WR_BLOCK_O = blk_r;
        BASE_WB_OK_O   = bwb_r;
        STATE_UNDO_O   = undo_r;
    end

    // fast entry sets both masks and fast mode one cycle after acceptance
    AST_FIQ_ENTRY: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (st_r == ST_RUN && kind == EXC_FIQ) |=> (psr_r[4:0] == MODE_FIQ && psr_r[7:6] == 2'b11
            && vec_r == VEC_FIQ))
        else $error("fast entry state wrong");
    AST_IRQ_KEEP_F: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (st_r == ST_RUN && kind == EXC_IRQ) |=> (psr_r[BIT_FMASK] == $past(psr_r[BIT_FMASK])
            && psr_r[4:0] == MODE_IRQ))
        else $error("normal entry changed fast mask");
    AST_USER_MASK: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (PSR_WR_I && !priv && kind == EXC_NONE && !INSTR_END_I.is_return)
            |=> psr_r[7:6] == $past(psr_r[7:6]))
        else $error("user write changed masks");
    AST_DATA_FAULT_LINK: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (st_r == ST_RUN && kind == EXC_DATA_FAULT) |=> (link_r == $past(INSTR_END_I.pc) + OFS_8))
        else $error("data fault link wrong");
    AST_PRIO_DATA_FAULT: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (INSTR_END_I.valid && data_fault_r) |-> kind == EXC_DATA_FAULT)
        else $error("data fault not top priority");
    sequence s_data_fault_chain;
        st_r == ST_RUN && kind == EXC_DATA_FAULT && fiq_lvl && !psr_r[BIT_FMASK];
    endsequence
    AST_CHAIN: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        s_data_fault_chain |=> vec_r == VEC_DATA_FAULT ##1 (vec_r == VEC_FIQ && entry_r))
        else $error("fast entry did not follow data fault");
    AST_MASKED: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (psr_r[BIT_FMASK] && psr_r[BIT_IMASK]) |-> !(kind inside {EXC_FIQ, EXC_IRQ}))
        else $error("masked interrupt taken");
    AST_COMPACT_CLR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (st_r == ST_RUN && kind != EXC_NONE) |=> (!psr_r[BIT_COMPACT] && saved_status_reg_r == $past(psr_r)))
        else $error("entry did not save status or clear compact");
    sequence s_fiq_async_low;
        !FAST_IRQ_N_I ##1 !IRQ_SYNC_SELECT_I ##1 !IRQ_SYNC_SELECT_I;
    endsequence
    AST_FIQ_LAT: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        (s_fiq_async_low ##0 (st_r == ST_RUN && INSTR_END_I.valid && !data_fault_r
            && !psr_r[BIT_FMASK])) |-> fiq_lvl ##[1:FIQ_ENTRY_MAX] entry_r)
        else $error("fast request latency too long");
endmodule : exc_entry

// ### dv/irq_mmu_model.sv
/* Far side of the exception unit: fast and normal interrupt sources and the
   memory fault line of the memory management unit.
   Assumes the bench commands each source on the core clock. */
`timescale 1ns/1ps
module irq_mmu_model (
    input  wire logic clk_i,
    input  wire logic fiq_on_i,
    input  wire logic irq_on_i,
    input  wire logic fault_on_i,
    input  wire logic cyc_valid_i,
    output logic      fast_irq_n_o,
    output logic      irq_req_n_o,
    output logic      mem_fault_o
);
    logic junk_r;

    initial begin
        fast_irq_n_o = 1'b1;
        irq_req_n_o  = 1'b1;
        junk_r       = 1'b0;
    end

    // requests are low levels held until the bench withdraws them
    always @(posedge clk_i) begin
        fast_irq_n_o <= ~fiq_on_i;
        irq_req_n_o  <= ~irq_on_i;
        junk_r       <= ~junk_r;
    end

    // outside an access the line carries garbage, so only the cycle qualifier may be trusted
    assign mem_fault_o = cyc_valid_i ? fault_on_i : junk_r;
endmodule : irq_mmu_model

// ### dv/tb_top.sv
/* Self-checking bench for the exception entry unit: drives instruction ends,
   memory cycles and status writes; a negedge monitor checks every entry except those raised by reset.
   Assumes exc_pkg, exc_entry and irq_mmu_model are compiled first. */
`timescale 1ns/1ps
module tb_top;
    import exc_pkg::*;
    typedef struct {
        logic [31:0] vec;
        logic [7:0]  st;
        logic        mcare;
        logic        lcare;
        logic [31:0] lk;
        logic [4:0]  smode;
    } note_t;
    logic        clk, rst, sync_sel, flush, psr_wr, blk_done, fiq_on, irq_on, fault_on;
    logic        fiq_n, irq_n, fault, entry, link_we, wr_blk, base_ok, undo, blk_q, mon_en;
    logic [31:0] psr_wd, saved_in, vector, link, status, saved, pc;
    logic [7:0]  st;
    mem_cycle_t  cyc;
    instr_end_t  iend_s;
    note_t       mn;
    note_t       eq[$];
    logic [31:0] lq[$];
    logic [2:0]  sq[$];
    int          error_cnt, compares, n;

    exc_entry dut (.CLK_I(clk), .SYS_RST_I(rst), .FAST_IRQ_N_I(fiq_n), .IRQ_REQ_N_I(irq_n),
        .IRQ_SYNC_SELECT_I(sync_sel), .MEM_FAULT_I(fault), .MEM_CYC_I(cyc),
        .INSTR_END_I(iend_s), .FLUSH_I(flush), .PSR_WR_I(psr_wr), .PSR_WDATA_I(psr_wd),
        .SAVED_PSR_I(saved_in), .BLOCK_DONE_I(blk_done), .ENTRY_O(entry), .VECTOR_O(vector),
        .LINK_O(link), .LINK_WE_O(link_we), .STATUS_O(status), .SAVED_STATUS_O(saved),
        .REG_WR_BLOCK_O(wr_blk), .BASE_WB_OK_O(base_ok), .STATE_UNDO_O(undo));
    irq_mmu_model far (.clk_i(clk), .fiq_on_i(fiq_on), .irq_on_i(irq_on),
        .fault_on_i(fault_on), .cyc_valid_i(cyc.valid), .fast_irq_n_o(fiq_n),
        .irq_req_n_o(irq_n), .mem_fault_o(fault));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic final_report;
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick

    task automatic psr(input logic [7:0] d);
        psr_wr <= 1'b1;
        psr_wd <= {24'h0, d};
        @(posedge clk);
        psr_wr <= 1'b0;
        // user mode cannot touch the masks or the mode
        if (st[4:0] != MODE_USR) begin
            st[7:6] = d[7:6];
            st[4:0] = d[4:0];
        end
        tick(2);
        @(negedge clk);
        chk("status", {24'h0, st}, {24'h0, status[7:0]});
        @(posedge clk);
    endtask : psr

    task automatic ie(input logic [31:0] p, input logic [5:0] f, input logic fl);
        iend_s <= {1'b1, p, f};
        flush  <= fl;
        @(posedge clk);
        iend_s <= '0;
        flush  <= 1'b0;
        tick(3);
    endtask : ie

    task automatic ex(input logic [31:0] v, input logic [4:0] m, input logic lc,
                      input logic [31:0] lk);
        note_t x;
        x.smode = st[4:0];
        st[4:0] = m;
        st[5]   = 1'b0;
        if (m == MODE_FIQ) st[7:6] = 2'b11;
        if (m == MODE_IRQ) st[7] = 1'b1;
        x.vec   = v;
        x.st    = st;
        x.mcare = (m == MODE_FIQ) || (m == MODE_IRQ);
        x.lcare = lc;
        x.lk    = lk;
        eq.push_back(x);
    endtask : ex

    // k: 0 word transfer, 1 atomic swap, 2 block transfer
    task automatic mflt(input int k);
        // a block transfer also writes back its base
        sq.push_back(k == 2 ? 3'b101 : 3'b100 >> k);
        fault_on <= 1'b1;
        cyc      <= {1'b1, 1'b0, k == 1, k == 2, k == 0};
        @(posedge clk);
        cyc      <= '0;
        fault_on <= 1'b0;
        tick(2);
        if (k == 2) begin
            blk_done <= 1'b1;
            @(posedge clk);
            blk_done <= 1'b0;
            @(negedge clk);
            chk("write block", 32'h0, {31'h0, wr_blk});
            @(posedge clk);
        end
    endtask : mflt

    always @(negedge clk) begin
        if (mon_en) begin
            if (entry) begin
                chk("pending entry", 32'h1, {31'h0, eq.size() > 0});
                if (eq.size() > 0) begin
                    mn = eq.pop_front();
                    chk("vector", mn.vec, vector);
                    chk("mode", {26'h0, mn.st[5:0]}, {26'h0, status[5:0]});
                    if (mn.mcare) chk("masks", {30'h0, mn.st[7:6]}, {30'h0, status[7:6]});
                    chk("saved mode", {27'h0, mn.smode}, {27'h0, saved[4:0]});
                    if (mn.lcare) chk("link", mn.lk, link);
                end
            end else if (link_we) begin
                chk("pending link", 32'h1, {31'h0, lq.size() > 0});
                if (lq.size() > 0) chk("link", lq.pop_front(), link);
            end
            if (base_ok || undo || (wr_blk && !blk_q)) begin
                chk("pending fault", 32'h1, {31'h0, sq.size() > 0});
                if (sq.size() > 0) chk("fault", {29'h0, sq.pop_front()}, {29'h0, base_ok, undo, wr_blk});
            end
            blk_q = wr_blk;
        end
    end

    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    initial begin
        {rst, sync_sel} = 2'b11;
        {flush, psr_wr, blk_done, fiq_on, irq_on, fault_on, blk_q, mon_en} = '0;
        {psr_wd, saved_in, cyc, iend_s} = '0;
        {error_cnt, compares} = '0;
        st = 8'hd3;
        void'($urandom(32'h3e9c6f45));
        tick(10);
        rst <= 1'b0;
        tick(3);
        mon_en = 1'b1;
        chk("reset status", PSR_RESET, status);
        chk("reset vector", VEC_RESET, vector);
        psr(8'h13);
        pc = $urandom & 32'hffff_fffc;
        lq.push_back(pc + OFS_4);
        ie(pc, 6'b100000, 1'b0);
        for (int k = 0; k < 2; k++) begin
            pc = $urandom & 32'hffff_fffc;
            ex(k ? VEC_UND : VEC_SVC, k ? MODE_UND : MODE_SVC, 1'b1, pc + OFS_4);
            ie(pc, k ? 6'b001000 : 6'b010000, 1'b0);
            psr(8'h13);
        end
        ex(VEC_PREFETCH_FAULT, MODE_ABT, 1'b1, pc + OFS_4);
        ie(pc, 6'b000100, 1'b0);
        psr(8'h13);
        ie(pc, 6'b000100, 1'b1);
        fiq_on <= 1'b1;
        irq_on <= 1'b1;
        tick(2);
        ex(VEC_FIQ, MODE_FIQ, 1'b1, pc + OFS_4);
        ie(pc, 6'b010100, 1'b0);
        fiq_on <= 1'b0;
        ie(pc, 6'b000000, 1'b0);
        psr(8'h13);
        ex(VEC_IRQ, MODE_IRQ, 1'b1, pc + OFS_4);
        ie(pc, 6'b000100, 1'b0);
        psr(8'hd3);
        fiq_on <= 1'b1;
        tick(2);
        ie(pc, 6'b000000, 1'b0);
        {fiq_on, irq_on} <= 2'b00;
        tick(2);
        psr(8'h13);
        for (int k = 0; k < 3; k++) begin
            pc = $urandom & 32'hffff_fffc;
            mflt(k);
            ex(VEC_DATA_FAULT, MODE_ABT, 1'b1, pc + OFS_8);
            ie(pc, 6'b000000, 1'b0);
            psr(8'h13);
        end
        fiq_on <= 1'b1;
        mflt(0);
        ex(VEC_DATA_FAULT, MODE_ABT, 1'b1, pc + OFS_8);
        ex(VEC_FIQ, MODE_FIQ, 1'b1, VEC_DATA_FAULT + OFS_4);
        ie(pc, 6'b000000, 1'b0);
        fiq_on <= 1'b0;
        tick(2);
        psr(8'h13);
        saved_in <= 32'h0000_0053;
        ie(pc, 6'b000011, 1'b0);
        @(negedge clk);
        chk("restored status", 32'h53, {24'h0, status[7:0]});
        st = 8'h53;
        @(posedge clk);
        saved_in <= 32'h0000_0033;
        st = 8'h33;
        ie(pc, 6'b000011, 1'b0);
        lq.push_back(pc + OFS_2);
        ie(pc, 6'b100000, 1'b0);
        ex(VEC_SVC, MODE_SVC, 1'b1, pc + OFS_2);
        ie(pc, 6'b010000, 1'b0);
        psr(8'h10);
        psr(8'hd3);
        irq_on <= 1'b1;
        tick(2);
        ex(VEC_IRQ, MODE_IRQ, 1'b1, pc + OFS_4);
        ie(pc, 6'b000000, 1'b0);
        irq_on <= 1'b0;
        tick(2);
        psr(8'h13);
        sync_sel <= 1'b0;
        ex(VEC_FIQ, MODE_FIQ, 1'b1, pc + OFS_4);
        fiq_on <= 1'b1;
        @(posedge clk);
        iend_s <= {1'b1, pc, 6'b000000};
        n = 0;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (entry !== 1'b1 && n < 10);
        iend_s <= '0;
        chk("fast latency", 32'h1, {31'h0, n >= 2 && n <= T_MIN_LAT});
        fiq_on   <= 1'b0;
        sync_sel <= 1'b1;
        tick(4);
        // second reset from fast mode must bring back the reset status
        mon_en = 1'b0;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(2);
        chk("reset status", PSR_RESET, status);
        chk("reset vector", VEC_RESET, vector);
        final_report();
    end
endmodule : tb_top
